// >>> logic/bcw_map.svh
// Purpose: constants for the chopped-burst write checksum path
// Assumes: one beat per clock on the link, x16 organisation
// Notes:   offsets of beats inside a ten-beat write frame
`ifndef BCW_MAP_SVH
`define BCW_MAP_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define BCW_FRAME_BEATS   10
`define BCW_DATA_BEATS    4
`define BCW_CRC_BEAT      8
`define BCW_LAST_BEAT     9
`define BCW_HALF_OFFSET   4
`define BCW_TREE_BITS     36
`define BCW_LANE_BITS     8
`define BCW_MASK_POS      32

// ****************************************************************
// checksum
// ****************************************************************
`define BCW_CRC_POLY      8'h07
`define BCW_CRC_INIT      8'h00

`endif

// >>> logic/bcw_pkg.sv
// Purpose: shared types and tree-input mapping for both link ends
// Assumes: bcw_map.svh constants
// Notes:   both ends call the same mapping so their checksums agree
`include "bcw_map.svh"

package bcw_pkg;

    typedef logic [7:0]  bcw_crc_t;
    typedef logic [35:0] bcw_tree_t;
    typedef logic [31:0] bcw_lane_data_t;
    typedef logic [3:0]  bcw_lane_mask_t;

    // ****************************************************************
    // tree input for one byte lane
    // ****************************************************************
    // data: beat b of lane bit i at [8*b+i]; mask: beat b at [b]
    function automatic bcw_tree_t bcw_tree_in(input bcw_lane_data_t data,
                                              input bcw_lane_mask_t mask,
                                              input logic           half,
                                              input logic           en);
        logic [71:0] frame;
        bcw_tree_t   tree;
        int          sh;
        frame = {72{1'b1}};
        tree  = {36{1'b1}};
        sh    = half ? `BCW_HALF_OFFSET : 0;
        // beats sit in the selected half of an eight-beat frame
        for (int i = 0; i < 8; i++) begin
            for (int b = 0; b < 4; b++) begin
                frame[8*i + b + sh] = data[8*b + i];
            end
        end
        for (int b = 0; b < 4; b++) begin
            frame[64 + b + sh] = en ? mask[b] : 1'b1;
        end
        // upper half folds onto the first-nibble positions
        for (int i = 0; i < 9; i++) begin
            for (int b = 0; b < 4; b++) begin
                tree[4*i + b] = frame[8*i + b + sh];
            end
        end
        return tree;
    endfunction

    // ****************************************************************
    // serial checksum over the 36 tree bits, msb first
    // ****************************************************************
    function automatic bcw_crc_t bcw_crc(input bcw_tree_t v);
        bcw_crc_t c;
        logic     fb;
        c = `BCW_CRC_INIT;
        for (int k = 35; k >= 0; k--) begin
            fb = c[7] ^ v[k];
            c  = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ `BCW_CRC_POLY;
            end
        end
        return c;
    endfunction

endpackage

// >>> logic/bcw_if.sv
// Purpose: write link between controller end and device end
// Assumes: both ends on sys_clk_i, one beat per cycle
// Notes:   write-only path, so no lane is turned around
`timescale 1ns/1ps

interface bcw_if;
    logic        frame_start;              // beat 0 of a frame
    logic [15:0] data_lane_bit0;           // data lanes, bit 0 upward
    logic [1:0]  data_mask_lane;           // lower, upper mask/inversion
    logic        burst_half_select_bit;    // chosen half of the burst
    logic        mask_en;                  // mask function on
    logic        inv_en;                   // inversion function on
    logic        dev_ready;                // device can take one frame

    modport host (output frame_start, data_lane_bit0, data_mask_lane,
                  burst_half_select_bit, mask_en, inv_en, input dev_ready);
    modport dev  (input frame_start, data_lane_bit0, data_mask_lane,
                  burst_half_select_bit, mask_en, inv_en, output dev_ready);
endinterface

// >>> logic/bcw_host.sv
// Purpose: controller end, sends chopped four-beat writes with checksum
// Assumes: device ready is registered on sys_clk_i
// Notes:   a frame is ten beats; next frame waits for dev_ready again
`timescale 1ns/1ps
`include "bcw_map.svh"

module bcw_host (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic        usr_valid_i,
    output logic             usr_ready_o,
    input  wire logic [63:0] usr_data_i,
    input  wire logic [7:0]  usr_mask_i,
    input  wire logic        usr_half_i,
    input  wire logic        mask_en_i,
    input  wire logic        inv_en_i,
    bcw_if.host              link
);
    import bcw_pkg::*;

    typedef enum logic [0:0] {BCW_H_IDLE, BCW_H_SEND} bcw_hst_e;

    bcw_hst_e    state_r;
    logic [3:0]  beat_r;
    logic [63:0] data_r;
    logic [7:0]  mask_r;
    logic [15:0] crc_r;
    logic        take;
    logic [31:0] lo_d;
    logic [31:0] hi_d;

    assign take = (state_r == BCW_H_IDLE) && usr_valid_i && usr_ready_o;

    // ****************************************************************
    // split user beats into byte lanes for both checksums
    // ****************************************************************
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            lo_d[8*b +: 8] = usr_data_i[16*b +: 8];
            hi_d[8*b +: 8] = usr_data_i[16*b + 8 +: 8];
        end
    end

    // ****************************************************************
    // frame sequencer
    // ****************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r     <= BCW_H_IDLE;
            beat_r      <= 4'h0;
            usr_ready_o <= 1'b0;
        end else begin
            case (state_r)
                BCW_H_IDLE: begin
                    usr_ready_o <= link.dev_ready && !take;  // waits on device room
                    if (take) begin
                        state_r <= BCW_H_SEND;
                        beat_r  <= 4'h0;
                    end
                end
                BCW_H_SEND: begin
                    usr_ready_o <= 1'b0;
                    beat_r      <= beat_r + 4'h1;
                    if (beat_r == 4'(`BCW_LAST_BEAT)) begin
                        state_r <= BCW_H_IDLE;
                    end
                end
                default: state_r <= BCW_H_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // capture of the accepted write and its checksums
    // ****************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            data_r                     <= 64'h0;
            mask_r                     <= 8'h0;
            crc_r                      <= 16'h0;
            link.burst_half_select_bit <= 1'b0;
            link.mask_en               <= 1'b0;
            link.inv_en                <= 1'b0;
        end else if (take) begin
            data_r                     <= usr_data_i;
            mask_r                     <= usr_mask_i;
            link.burst_half_select_bit <= usr_half_i;
            link.mask_en               <= mask_en_i;
            link.inv_en                <= inv_en_i;
            // same mapping as the device, one tree per lane
            crc_r[7:0]  <= bcw_crc(bcw_tree_in(lo_d, {usr_mask_i[6], usr_mask_i[4],
                           usr_mask_i[2], usr_mask_i[0]}, usr_half_i,
                           mask_en_i || inv_en_i));
            crc_r[15:8] <= bcw_crc(bcw_tree_in(hi_d, {usr_mask_i[7], usr_mask_i[5],
                           usr_mask_i[3], usr_mask_i[1]}, usr_half_i,
                           mask_en_i || inv_en_i));
        end
    end

    // ****************************************************************
    // lane drive: data, idle ones, checksum beat, trailing ones
    // ****************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            link.frame_start    <= 1'b0;
            link.data_lane_bit0 <= 16'hFFFF;
            link.data_mask_lane <= 2'h3;
        end else begin
            link.frame_start    <= take;
            link.data_lane_bit0 <= 16'hFFFF;
            link.data_mask_lane <= 2'h3;
            if (take) begin
                link.data_lane_bit0 <= usr_data_i[15:0];
                link.data_mask_lane <= usr_mask_i[1:0];
            end else if (state_r == BCW_H_SEND) begin
                if (beat_r < 4'(`BCW_DATA_BEATS - 1)) begin
                    link.data_lane_bit0 <= data_r[16*(beat_r+1) +: 16];
                    link.data_mask_lane <= mask_r[2*(beat_r+1) +: 2];
                end else if (beat_r == 4'(`BCW_CRC_BEAT - 1)) begin
                    link.data_lane_bit0 <= crc_r;  // mask lanes stay ones
                end
            end
        end
    end

endmodule

// >>> logic/bcw_dev.sv
// Purpose: device end, checks write checksum of chopped bursts
// Assumes: host keeps frames ten beats long and waits for dev_ready
// Notes:   accepted writes queue in a small fifo toward the array side
`timescale 1ns/1ps
`include "bcw_map.svh"

// ****************************************************************
// fifo with registered head
// ****************************************************************
module bcw_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready_o = (cnt_r < (AW+1)'(DEPTH));
    assign push       = in_valid_i && in_ready_o;
    // head register refills whenever it is empty or being taken
    assign pop        = (cnt_r != '0) && (!out_valid_o || out_ready_i);

    // storage writes, no reset needed
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output stage
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (pop) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rp_r];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule

// ****************************************************************
// device end
// ****************************************************************
module bcw_dev #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    bcw_if.dev               link,
    output logic             usr_valid_o,
    input  wire logic        usr_ready_i,
    output logic [63:0]      usr_data_o,
    output logic [7:0]       usr_mask_o,
    output logic             usr_half_o,
    output logic [1:0]       crc_err_o
);
    import bcw_pkg::*;

    localparam int FW = 73;

    typedef enum logic [0:0] {BCW_D_IDLE, BCW_D_RECV} bcw_dst_e;

    bcw_dst_e    state_r;
    logic [3:0]  beat_r;
    logic [63:0] data_r;
    logic [7:0]  mask_r;
    logic [15:0] crc_rx_r;
    logic        half_r;
    logic        en_r;
    logic        last;
    logic        f_in_ready;
    logic [31:0] lo_d;
    logic [31:0] hi_d;
    bcw_tree_t   tree_lo;
    bcw_tree_t   tree_hi;
    bcw_crc_t    crc_lo;
    bcw_crc_t    crc_hi;

    assign last = (state_r == BCW_D_RECV) && (beat_r == 4'(`BCW_LAST_BEAT));

    // ****************************************************************
    // frame receive
    // ****************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= BCW_D_IDLE;
            beat_r  <= 4'h0;
        end else begin
            case (state_r)
                BCW_D_IDLE: begin
                    if (link.frame_start) begin
                        state_r <= BCW_D_RECV;
                        beat_r  <= 4'h1;
                    end
                end
                BCW_D_RECV: begin
                    beat_r <= beat_r + 4'h1;
                    if (last) begin
                        state_r <= BCW_D_IDLE;
                    end
                end
                default: state_r <= BCW_D_IDLE;
            endcase
        end
    end

    // beat capture: data beats, then the checksum beat
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            data_r   <= 64'h0;
            mask_r   <= 8'h0;
            crc_rx_r <= 16'h0;
            half_r   <= 1'b0;
            en_r     <= 1'b0;
        end else if (state_r == BCW_D_IDLE && link.frame_start) begin
            data_r[15:0] <= link.data_lane_bit0;
            mask_r[1:0]  <= link.data_mask_lane;
            half_r       <= link.burst_half_select_bit;
            en_r         <= link.mask_en || link.inv_en;
        end else if (state_r == BCW_D_RECV) begin
            if (beat_r < 4'(`BCW_DATA_BEATS)) begin
                data_r[16*beat_r +: 16] <= link.data_lane_bit0;
                mask_r[2*beat_r +: 2]   <= link.data_mask_lane;
            end else if (beat_r == 4'(`BCW_CRC_BEAT)) begin
                crc_rx_r <= link.data_lane_bit0;
            end
        end
    end

    // ****************************************************************
    // two identical trees, one per byte lane
    // ****************************************************************
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            lo_d[8*b +: 8] = data_r[16*b +: 8];
            hi_d[8*b +: 8] = data_r[16*b + 8 +: 8];
        end
        tree_lo = bcw_tree_in(lo_d, {mask_r[6], mask_r[4], mask_r[2], mask_r[0]},
                              half_r, en_r);
        tree_hi = bcw_tree_in(hi_d, {mask_r[7], mask_r[5], mask_r[3], mask_r[1]},
                              half_r, en_r);
        crc_lo  = bcw_crc(tree_lo);
        crc_hi  = bcw_crc(tree_hi);
    end

    // per-lane mismatch pulse in the cycle after the frame's last beat
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            crc_err_o <= 2'b00;
        end else begin
            crc_err_o[0] <= last && (crc_lo != crc_rx_r[7:0]);
            crc_err_o[1] <= last && (crc_hi != crc_rx_r[15:8]);
        end
    end

    // ready drops while a frame is in flight and on the push cycle,
    // so the fill count is seen settled before the next frame
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            link.dev_ready <= 1'b0;
        end else begin
            link.dev_ready <= f_in_ready && (state_r == BCW_D_IDLE)
                              && !link.frame_start && !last;
        end
    end

    // ****************************************************************
    // queue toward the user side; a failing write is still passed on
    // ****************************************************************
    bcw_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (last),
        .in_ready_o  (f_in_ready),
        .in_data_i   ({half_r, mask_r, data_r}),
        .out_valid_o (usr_valid_o),
        .out_ready_i (usr_ready_i),
        .out_data_o  ({usr_half_o, usr_mask_o, usr_data_o})
    );

endmodule

// >>> tb/bcw_link_properties.sv
// Purpose: frame timing checks on the link between host and device ends
// Assumes: one clock, synchronous active-high reset
// Notes:   watches the first link only; the fault link is judged by the bench
`timescale 1ns/1ps

module bcw_link_chk (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic        frame_start,
    input  wire logic [15:0] data_lane_bit0,
    input  wire logic [1:0]  data_mask_lane,
    input  wire logic        burst_half_select_bit,
    input  wire logic        mask_en,
    input  wire logic        inv_en,
    input  wire logic        dev_ready
);
    // ************************
    // frame properties
    // ************************
    // one domain only, so clock and reset are given once
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_start_after_ready:
        assert property (frame_start |-> $past(dev_ready)) else $error("start without ready");
    a_ready_low_frame:
        assert property (frame_start |-> ##1 !dev_ready [*8]) else $error("ready in frame");
    a_pad_beats_ones:
        assert property (frame_start |-> ##4 (data_lane_bit0 == 16'hFFFF
            && data_mask_lane == 2'b11) [*4]) else $error("pad beats not ones");
    a_tail_beat_ones:
        assert property (frame_start |-> ##9 data_lane_bit0 == 16'hFFFF
            && data_mask_lane == 2'b11) else $error("last beat not ones");
    a_crc_beat_mask:
        assert property (frame_start |-> ##8 data_mask_lane == 2'b11)
            else $error("mask lane busy at checksum");
    a_half_held:
        assert property (frame_start |-> ##1 $stable(burst_half_select_bit) [*8])
            else $error("half moved in frame");
    a_enables_held:
        assert property (frame_start |=> ($stable(mask_en) && $stable(inv_en)) [*8])
            else $error("enables moved in frame");
    a_start_spacing:
        assert property (frame_start |=> !frame_start [*8] ##1 !frame_start ##1 !frame_start)
            else $error("frames too close");

    // upper-half frames must really occur
    c_half_one: cover property (frame_start && burst_half_select_bit);
endmodule

// >>> tb/tb_burst_chop_write_crc_input_map.sv
// Purpose: self-checking bench for both link ends and the device fifo
// Assumes: one clock; checksum reference written here, not shared
// Notes:   a second link carries hand-made frames with faults
`timescale 1ns/1ps
`include "bcw_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end

module tb_burst_chop_write_crc_input_map;
    typedef struct packed {
        logic [63:0] d;
        logic [7:0]  m;
        logic        h;
        logic        me;
        logic        ie;
    } bcw_tb_row_s;

    logic        sys_clk, srst, usr_valid, usr_half, men, ien, dv_ready, h_rdy;
    logic        d_valid, d_half;
    logic [63:0] usr_data, d_data;
    logic [7:0]  usr_mask, d_mask;
    logic [1:0]  crc_err, crc_err2;
    logic [72:0] pe;
    logic [72:0] exp_q[$];
    bcw_tb_row_s rows [8];
    int          n_mismatch, cmp_count, n_acc, i, k;
    bit          tk;

    bcw_if lk ();
    bcw_if lk2 ();

    bcw_host u_bcw_host (.sys_clk_i(sys_clk), .srst_i(srst), .usr_valid_i(usr_valid),
        .usr_ready_o(h_rdy), .usr_data_i(usr_data), .usr_mask_i(usr_mask),
        .usr_half_i(usr_half), .mask_en_i(men), .inv_en_i(ien), .link(lk.host));
    bcw_dev #(.FIFO_DEPTH(8)) u_bcw_dev (.sys_clk_i(sys_clk), .srst_i(srst), .link(lk.dev),
        .usr_valid_o(d_valid), .usr_ready_i(dv_ready), .usr_data_o(d_data),
        .usr_mask_o(d_mask), .usr_half_o(d_half), .crc_err_o(crc_err));
    bcw_dev u_bcw_dev_flt (.sys_clk_i(sys_clk), .srst_i(srst), .link(lk2.dev),
        .usr_valid_o(), .usr_ready_i(1'b1), .usr_data_o(), .usr_mask_o(),
        .usr_half_o(), .crc_err_o(crc_err2));
    bcw_link_chk u_bcw_link_chk (.sys_clk_i(sys_clk), .srst_i(srst),
        .frame_start(lk.frame_start), .data_lane_bit0(lk.data_lane_bit0),
        .data_mask_lane(lk.data_mask_lane), .burst_half_select_bit(lk.burst_half_select_bit),
        .mask_en(lk.mask_en), .inv_en(lk.inv_en), .dev_ready(lk.dev_ready));

    // ************************
    // helpers
    // ************************
    // free-running clock, 10 ns period
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // lane checksum rebuilt here so a shared slip cannot hide
    function automatic logic [7:0] ecrc(input logic [63:0] d, input logic [7:0] m,
                                        input logic en, input int ln);
        logic [35:0] t;
        logic [7:0]  c;
        for (int b = 0; b < 4; b++) begin
            for (int j = 0; j < 8; j++) t[4*j+b] = d[16*b+8*ln+j];
            t[32+b] = en ? m[2*b+ln] : 1'b1;
        end
        c = `BCW_CRC_INIT;
        for (int j = 35; j >= 0; j--) c = {c[6:0], 1'b0} ^ ((c[7] ^ t[j]) ? `BCW_CRC_POLY : 8'h00);
        return c;
    endfunction

    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic no_answer();
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        stop_test();
    endtask

    // one host write; beats compared as they pass on the wire
    task automatic wr(input bcw_tb_row_s r, input int lim, output bit taken);
        logic [15:0] crc;
        crc = {ecrc(r.d, r.m, r.me | r.ie, 1), ecrc(r.d, r.m, r.me | r.ie, 0)};
        taken = 1'b0;
        {usr_data, usr_mask, usr_half, men, ien} = r;
        usr_valid = 1'b1;
        for (k = 0; k < lim && h_rdy !== 1'b1; k++) @(negedge sys_clk);
        if (h_rdy !== 1'b1) begin
            usr_valid = 1'b0;
            return;
        end
        taken = 1'b1;
        exp_q.push_back({r.h, r.m, r.d});
        // beat 0 is on the lanes in the cycle right after the taking edge
        @(negedge sys_clk);
        usr_valid = 1'b0;
        for (k = 0; k < 10; k++) begin
            if (k == 0) `CHK(lk.burst_half_select_bit, r.h)
            if (k < 4) `CHK(lk.data_lane_bit0, r.d[16*k +: 16])
            else if (k == 8) `CHK(lk.data_lane_bit0, crc)
            else `CHK(lk.data_lane_bit0, 16'hFFFF)
            @(negedge sys_clk);
        end
        // error pulse stands one cycle, the one after the last beat
        `CHK(crc_err, 2'b00)
    endtask

    // hand-made frame on the fault link; flip spoils checksum bits
    task automatic fw(input bcw_tb_row_s r, input logic cen, input logic [15:0] flip,
                      input logic [1:0] err);
        logic [15:0] crc;
        crc = {ecrc(r.d, r.m, cen, 1), ecrc(r.d, r.m, cen, 0)} ^ flip;
        for (k = 0; k < 40 && lk2.dev_ready !== 1'b1; k++) @(negedge sys_clk);
        if (lk2.dev_ready !== 1'b1) no_answer();
        {lk2.burst_half_select_bit, lk2.mask_en, lk2.inv_en} = {r.h, r.me, r.ie};
        for (k = 0; k < 10; k++) begin
            lk2.frame_start = (k == 0);
            lk2.data_lane_bit0 = k < 4 ? r.d[16*k +: 16] : (k == 8 ? crc : 16'hFFFF);
            lk2.data_mask_lane = k < 4 ? r.m[2*k +: 2] : 2'b11;
            @(negedge sys_clk);
        end
        lk2.data_lane_bit0 = 16'hFFFF;
        lk2.data_mask_lane = 2'b11;
        // one-cycle error pulse, seen right after the last beat
        `CHK(crc_err2, err)
    endtask

    // each pop must match the oldest write sent
    always @(posedge sys_clk) begin
        if (!srst && d_valid === 1'b1 && dv_ready === 1'b1) begin
            pe = exp_q.size() ? exp_q.pop_front() : '1;
            `CHK({d_half, d_mask, d_data}, pe)
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        no_answer();
    end

    // ************************
    // main sequence
    // ************************
    initial begin
        rows = '{'{64'h0123456789ABCDEF, 8'hA5, 1'b0, 1'b0, 1'b0},
                 '{64'hFFFF0000FFFF0000, 8'h3C, 1'b0, 1'b1, 1'b0},
                 '{64'h0000000000000001, 8'h00, 1'b0, 1'b0, 1'b1},
                 '{64'hDEADBEEF0BADF00D, 8'h0F, 1'b0, 1'b1, 1'b1},
                 '{64'h8000000000000000, 8'h5A, 1'b1, 1'b0, 1'b0},
                 '{64'h13579BDF2468ACE0, 8'hC3, 1'b1, 1'b1, 1'b0},
                 '{64'hFFFFFFFFFFFFFFFF, 8'h00, 1'b1, 1'b0, 1'b1},
                 '{64'h0F0FF0F055AAAA55, 8'hE7, 1'b1, 1'b1, 1'b1}};
        {srst, usr_valid, usr_half, men, ien, dv_ready} = 6'b100001;
        {usr_data, usr_mask, n_mismatch, cmp_count} = '0;
        {lk2.frame_start, lk2.burst_half_select_bit, lk2.mask_en, lk2.inv_en} = 4'h0;
        {lk2.data_lane_bit0, lk2.data_mask_lane} = 18'h3FFFF;
        repeat (10) @(negedge sys_clk);
        `CHK({h_rdy, lk.dev_ready, lk.frame_start, d_valid, crc_err}, 6'h00)
        `CHK({lk.data_lane_bit0, lk.data_mask_lane}, 18'h3FFFF)
        srst = 1'b0;
        // device ready at the first edge after release, host one edge later
        @(negedge sys_clk);
        `CHK(h_rdy, 1'b0)
        `CHK({lk.dev_ready, h_rdy}, 2'b10)
        @(negedge sys_clk);
        `CHK(h_rdy, 1'b1)
        $display("test reset done");
        // every half and enable mix, back to back
        for (i = 0; i < 8; i++) begin
            wr(rows[i], 60, tk);
            `CHK(tk, 1'b1)
        end
        $display("test rows done");
        // stall the array side until the host is refused
        dv_ready = 1'b0;
        n_acc = 0;
        for (i = 0; i < 10; i++) begin
            wr(rows[i % 8], 60, tk);
            n_acc += tk;
        end
        `CHK(n_acc, 8)
        dv_ready = 1'b1;
        for (k = 0; k < 60 && exp_q.size() > 0; k++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        `CHK({d_valid, exp_q.size()}, 33'h0)
        $display("test fifo done");
        // faults and forced-ones cases on the second link
        fw(rows[0], 1'b0, 16'h0000, 2'b00);
        fw(rows[0], 1'b1, 16'h0000, 2'b11);
        fw(rows[5], 1'b1, 16'h0000, 2'b00);
        fw(rows[4], 1'b1, 16'h0000, 2'b11);
        fw(rows[5], 1'b1, 16'h0001, 2'b01);
        fw(rows[7], 1'b1, 16'h8000, 2'b10);
        $display("test faults done");
        stop_test();
    end
endmodule
